// ==== rtl/udid_pkg.sv ====
// Constants for the unique device identifier builder.
// Assumes a single core clock domain and word-indexed register port.
`default_nettype none
package udid_pkg;
  // ==========================================================
  // Register indices
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_IDS       = 4'h1;
  localparam logic [3:0] REG_VSID_FIX  = 4'h2;
  localparam logic [3:0] REG_UDID_W3   = 4'h3;
  localparam logic [3:0] REG_UDID_W2   = 4'h4;
  localparam logic [3:0] REG_UDID_W1   = 4'h5;
  localparam logic [3:0] REG_UDID_W0   = 4'h6;
  localparam logic [3:0] REG_STATUS    = 4'h7;
  // ==========================================================
  // Control register fields
  localparam int CTRL_ATYPE_LSB = 0;
  localparam int CTRL_PEC_BIT   = 2;
  localparam int CTRL_IPMI_BIT  = 3;
  localparam int CTRL_ASF_BIT   = 4;
  localparam int CTRL_OEM_BIT   = 5;
  localparam int CTRL_NOTIFY_BIT = 6;
  localparam int CTRL_SREV_LSB  = 8;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [31:0] IDS_RESET  = 32'h0000_0000;
  localparam logic [31:0] VSID_RESET = 32'h0000_0000;
  // ==========================================================
  // Identifier encodings
  localparam logic [1:0] ATYPE_FIXED  = 2'h0;
  localparam logic [1:0] ATYPE_PERSIST = 2'h1;
  localparam logic [1:0] ATYPE_VOLATILE = 2'h2;
  localparam logic [1:0] ATYPE_RANDOM = 2'h3;
  localparam logic [2:0] UDID_VERSION = 3'h1;
  localparam logic [3:0] BUS_VERSION  = 4'h4;
  localparam logic [6:0] HOST_ADDR    = 7'h08;
  localparam logic [31:0] LFSR_SEED   = 32'hACE1_1D5B;
  localparam int UDID_W = 128;
  // ==========================================================
  // Serial presentation states
  typedef enum logic [0:0] {
    SH_IDLE,
    SH_SHIFT
  } shift_state_t;
endpackage
`default_nettype wire

// ==== rtl/udid_builder.sv ====
// Unique device identifier builder with random identifier life cycle.
// Assumes strobes from same-clock logic; link clock and NV pins are asynchronous.
//
// Operation
// (RULE_01) PEC capability bit only when fully supported
// (RULE_02) Capability reserved bits read as zero
// (RULE_03) Version byte top two bits zero
// (RULE_04) Report identifier version pattern 001
// (RULE_05) Silicon revision code in low bits
// (RULE_06) Interface low nibble reports bus 0100
// (RULE_07) Interface bits 6,5,4 flag access kinds
// (RULE_08) Interface bits 15 to 7 stay zero
// (RULE_09) Zero subsystem vendor forces zero subsystem device
// (RULE_10) Subsystem identifiers come from non-volatile storage
// (RULE_11) Assignable device provides distinguishing specific identifier
// (RULE_12) Preassigned identifier has 16+ unique bits
// (RULE_13) Fixed address device still presents field
// (RULE_14) Random identifier at least 16 bits
// (RULE_15) Random device forbids persistent and fixed addresses
// (RULE_16) Fixed mode uses constant specific identifier
// (RULE_17) Random value held except regeneration events
// (RULE_18) Reset-device command regenerates random value
// (RULE_19) Read collision regenerates, then host notify
// (RULE_20) Present full 128-bit identifier
// (RULE_21) Random device reports address type 11
// (RULE_22) Notify to host 0001000 with own address
// (RULE_23) Free-running generator feeds random values
//
// Strobed register access and the register addresses were chosen for this implementation.
`default_nettype none
module udid_builder #(
  parameter int RAND_W = 32
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire logic [15:0]         nv_subsys_vendor,
  input  wire logic [15:0]         nv_subsys_device,
  input  wire logic                reset_device,
  input  wire logic                rd_collision,
  input  wire logic [6:0]          own_addr,
  input  wire logic                link_clk,
  input  wire logic                udid_load,
  output logic                     udid_sdo,
  output logic                     udid_busy,
  output logic [127:0]             udid,
  output logic                     notify_req,
  output logic [6:0]               notify_host,
  output logic [6:0]               notify_src,
  output logic [15:0]              notify_status,
  output logic                     persist_allowed,
  output logic                     fixed_allowed
);
  // ==========================================================
  // Registers
  logic [10:0]         ctrl_r;
  logic [31:0]         ids_r;
  logic [31:0]         vsid_fix_r;
  logic [31:0]         lfsr_r;
  logic [RAND_W-1:0]   rand_r;
  logic                init_done_r;
  logic [15:0]         ssv_s1_r, ssv_r, ssd_s1_r, ssd_r;
  logic [2:0]          lclk_r;
  logic [127:0]        udid_nxt;
  logic [127:0]        shift_r;
  logic [6:0]          bitcnt_r;
  udid_pkg::shift_state_t sh_state_r;
  logic                random_mode;
  logic                regen;
  logic [31:0]         vsid;
  logic [15:0]         ssd_eff;

  assign random_mode = ctrl_r[udid_pkg::CTRL_ATYPE_LSB +: 2] == udid_pkg::ATYPE_RANDOM;
  // A zero-seeded generator would lock up, so the seed is a fixed non-zero constant.
  assign regen = !init_done_r || reset_device || rd_collision; // RULE_17

  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r     <= udid_pkg::CTRL_RESET;
      ids_r      <= udid_pkg::IDS_RESET;
      vsid_fix_r <= udid_pkg::VSID_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        udid_pkg::REG_CTRL:     ctrl_r     <= reg_wdata[10:0];
        udid_pkg::REG_IDS:      ids_r      <= reg_wdata;
        udid_pkg::REG_VSID_FIX: vsid_fix_r <= reg_wdata; // RULE_12 RULE_13 RULE_16
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Register reads, data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        udid_pkg::REG_CTRL:     reg_rdata <= {21'h00_0000, ctrl_r};
        udid_pkg::REG_IDS:      reg_rdata <= ids_r;
        udid_pkg::REG_VSID_FIX: reg_rdata <= vsid_fix_r;
        udid_pkg::REG_UDID_W3:  reg_rdata <= udid[127:96];
        udid_pkg::REG_UDID_W2:  reg_rdata <= udid[95:64];
        udid_pkg::REG_UDID_W1:  reg_rdata <= udid[63:32];
        udid_pkg::REG_UDID_W0:  reg_rdata <= udid[31:0];
        udid_pkg::REG_STATUS:   reg_rdata <= 32'(rand_r);
        default:                reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Non-volatile subsystem identifiers, synchronised
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ssv_s1_r <= 16'h0000;
      ssv_r    <= 16'h0000;
      ssd_s1_r <= 16'h0000;
      ssd_r    <= 16'h0000;
    end else begin
      ssv_s1_r <= nv_subsys_vendor; // RULE_10
      ssv_r    <= ssv_s1_r;
      ssd_s1_r <= nv_subsys_device;
      ssd_r    <= ssd_s1_r;
    end
  end

  // ==========================================================
  // Random identifier generation and retention
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lfsr_r <= udid_pkg::LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]}; // RULE_23
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rand_r      <= '0;
      init_done_r <= 1'b0;
    end else begin
      init_done_r <= 1'b1;
      if (regen) begin
        rand_r <= lfsr_r[RAND_W-1:0]; // RULE_14 RULE_18 RULE_19
      end
    end
  end

  // ==========================================================
  // Host notify after a read collision
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      notify_req    <= 1'b0;
      notify_host   <= 7'h00;
      notify_src    <= 7'h00;
      notify_status <= 16'h0000;
    end else begin
      notify_req <= rd_collision && ctrl_r[udid_pkg::CTRL_NOTIFY_BIT]; // RULE_19
      if (rd_collision) begin
        notify_host   <= udid_pkg::HOST_ADDR; // RULE_22
        notify_src    <= own_addr;
        notify_status <= lfsr_r[15:0];
      end
    end
  end

  // ==========================================================
  // Identifier assembly
  always_comb begin
    vsid = random_mode ? 32'(rand_r) : vsid_fix_r; // RULE_11
    ssd_eff = (ssv_r == 16'h0000) ? 16'h0000 : ssd_r; // RULE_09
    udid_nxt = {ctrl_r[udid_pkg::CTRL_ATYPE_LSB +: 2], 5'h00, // RULE_02 RULE_21
                ctrl_r[udid_pkg::CTRL_PEC_BIT], // RULE_01
                2'h0, udid_pkg::UDID_VERSION, // RULE_03 RULE_04
                ctrl_r[udid_pkg::CTRL_SREV_LSB +: 3], // RULE_05
                ids_r[15:0], ids_r[31:16],
                9'h000, ctrl_r[udid_pkg::CTRL_IPMI_BIT], // RULE_08
                ctrl_r[udid_pkg::CTRL_ASF_BIT], ctrl_r[udid_pkg::CTRL_OEM_BIT], // RULE_07
                udid_pkg::BUS_VERSION, // RULE_06
                ssv_r, ssd_eff, vsid}; // RULE_20
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      udid            <= '0;
      persist_allowed <= 1'b0;
      fixed_allowed   <= 1'b0;
    end else begin
      udid            <= udid_nxt;
      persist_allowed <= !random_mode; // RULE_15
      fixed_allowed   <= !random_mode;
    end
  end

  // ==========================================================
  // Serial presentation, one bit per sampled link clock rise
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lclk_r <= 3'h0;
    end else begin
      lclk_r <= {lclk_r[1:0], link_clk};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sh_state_r <= udid_pkg::SH_IDLE;
      shift_r    <= '0;
      bitcnt_r   <= 7'h00;
      udid_sdo   <= 1'b1;
      udid_busy  <= 1'b0;
    end else begin
      case (sh_state_r)
        udid_pkg::SH_IDLE: begin
          if (udid_load) begin
            shift_r    <= udid;
            bitcnt_r   <= 7'h7F;
            udid_busy  <= 1'b1;
            sh_state_r <= udid_pkg::SH_SHIFT;
          end
        end
        udid_pkg::SH_SHIFT: begin
          if (lclk_r[1] && !lclk_r[2]) begin
            udid_sdo <= shift_r[127];
            shift_r  <= {shift_r[126:0], 1'b1};
            bitcnt_r <= bitcnt_r - 7'h01;
            if (bitcnt_r == 7'h00) begin
              udid_busy  <= 1'b0;
              sh_state_r <= udid_pkg::SH_IDLE;
            end
          end
        end
        default: sh_state_r <= udid_pkg::SH_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_cap_reserved;
    udid[125:121] == 5'h00;
  endproperty
  a_cap_reserved: assert property (p_cap_reserved) else $error("cap reserved set"); // RULE_02

  property p_ver_byte;
    init_done_r |-> udid[119:115] == 5'h01;
  endproperty
  a_ver_byte: assert property (p_ver_byte) else $error("version byte wrong"); // RULE_04

  property p_srev;
    reg_wr && reg_addr == udid_pkg::REG_CTRL |=> ##1 udid[114:112] == $past(reg_wdata[10:8], 2);
  endproperty
  a_srev: assert property (p_srev) else $error("silicon revision not shown"); // RULE_05

  property p_intf;
    init_done_r |-> udid[79:64] == {9'h000, $past(ctrl_r[5:3]), udid_pkg::BUS_VERSION};
  endproperty
  a_intf: assert property (p_intf) else $error("interface field wrong"); // RULE_08

  property p_ssid;
    udid[63:48] == 16'h0000 |-> udid[47:32] == 16'h0000;
  endproperty
  a_ssid: assert property (p_ssid) else $error("subsystem device not zero"); // RULE_09

  property p_hold;
    !regen |=> rand_r == $past(rand_r);
  endproperty
  a_hold: assert property (p_hold) else $error("random value drifted"); // RULE_17

  property p_regen;
    reset_device |=> rand_r == $past(lfsr_r[RAND_W-1:0]);
  endproperty
  a_regen: assert property (p_regen) else $error("no regeneration"); // RULE_18

  property p_notify;
    rd_collision && ctrl_r[udid_pkg::CTRL_NOTIFY_BIT] |=>
      notify_req && notify_host == udid_pkg::HOST_ADDR && notify_src == $past(own_addr);
  endproperty
  a_notify: assert property (p_notify) else $error("host notify missing"); // RULE_22

  property p_random_type;
    random_mode |=> udid[127:126] == 2'h3 && !persist_allowed && !fixed_allowed;
  endproperty
  a_random_type: assert property (p_random_type) else $error("random mode flags"); // RULE_15

  property p_pec;
    init_done_r |-> udid[120] == $past(ctrl_r[udid_pkg::CTRL_PEC_BIT]);
  endproperty
  a_pec: assert property (p_pec) else $error("capability bit not from control"); // RULE_01

  property p_ver_top;
    udid[119:118] == 2'h0;
  endproperty
  a_ver_top: assert property (p_ver_top) else $error("version reserved set"); // RULE_03

  property p_bus_ver;
    init_done_r |-> udid[67:64] == udid_pkg::BUS_VERSION;
  endproperty
  a_bus_ver: assert property (p_bus_ver) else $error("bus version wrong"); // RULE_06

  property p_access;
    init_done_r |-> udid[70:68] == {$past(ctrl_r[udid_pkg::CTRL_IPMI_BIT]),
      $past(ctrl_r[udid_pkg::CTRL_ASF_BIT]), $past(ctrl_r[udid_pkg::CTRL_OEM_BIT])};
  endproperty
  a_access: assert property (p_access) else $error("access flags wrong"); // RULE_07

  property p_ssv_src;
    init_done_r |-> udid[63:48] == $past(ssv_r);
  endproperty
  a_ssv_src: assert property (p_ssv_src) else $error("subsystem vendor lost"); // RULE_10

  property p_vsid_fix;
    init_done_r && !$past(random_mode) |-> udid[31:0] == $past(vsid_fix_r);
  endproperty
  a_vsid_fix: assert property (p_vsid_fix) else $error("fixed specific id lost"); // RULE_16

  property p_vsid_rand;
    init_done_r && $past(random_mode) |-> udid[31:0] == 32'($past(rand_r));
  endproperty
  a_vsid_rand: assert property (p_vsid_rand) else $error("random id not shown"); // RULE_14

  property p_collide;
    rd_collision |=> rand_r == $past(lfsr_r[RAND_W-1:0]);
  endproperty
  a_collide: assert property (p_collide) else $error("no regeneration on collision"); // RULE_19

  property p_notify_off;
    rd_collision && !ctrl_r[udid_pkg::CTRL_NOTIFY_BIT] |=> !notify_req;
  endproperty
  a_notify_off: assert property (p_notify_off) else $error("notify while disabled"); // RULE_19

  property p_notify_cause;
    notify_req |-> $past(rd_collision);
  endproperty
  a_notify_cause: assert property (p_notify_cause) else $error("stray notify"); // RULE_22

  property p_notify_status;
    rd_collision |=> notify_status == $past(lfsr_r[15:0]);
  endproperty
  a_notify_status: assert property (p_notify_status) else $error("status wrong"); // RULE_22

  property p_fixed_flags;
    init_done_r && !random_mode |=> persist_allowed && fixed_allowed;
  endproperty
  a_fixed_flags: assert property (p_fixed_flags) else $error("modes blocked"); // RULE_15

  property p_load;
    sh_state_r == udid_pkg::SH_IDLE && udid_load |=> udid_busy && shift_r == $past(udid);
  endproperty
  a_load: assert property (p_load) else $error("identifier not captured"); // RULE_20

  property p_shift_bit;
    sh_state_r == udid_pkg::SH_SHIFT && lclk_r[1] && !lclk_r[2] |=>
      udid_sdo == $past(shift_r[127]);
  endproperty
  a_shift_bit: assert property (p_shift_bit) else $error("wrong bit shifted"); // RULE_20

  property p_lfsr_run;
    init_done_r |-> lfsr_r != 32'h0000_0000 && lfsr_r != $past(lfsr_r);
  endproperty
  a_lfsr_run: assert property (p_lfsr_run) else $error("generator stalled"); // RULE_23

  c_collision: cover property (rd_collision ##1 notify_req);
  c_shift_done: cover property (udid_busy ##1 !udid_busy);
  c_random: cover property (random_mode && reset_device);
  c_fixed_load: cover property (!random_mode && udid_load);
endmodule
`default_nettype wire

// ==== test/link_master_model.sv ====
// Behavioural link master that clocks the identifier out of the device.
// Assumes the device shifts one bit per link clock rise and settles well within 200 ns.
`default_nettype none
module link_master_model (
  input  wire logic         start,
  input  wire logic         sdo,
  output logic              link_clk,
  output logic [127:0]      rx,
  output logic              done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Frame clocking
  // The clock stands low outside the frame, so the device sees no stray edges.
  // Bits are taken just before the next rise, the latest point the device must hold them.
  initial begin
    link_clk = 1'h0;
    rx = '0;
    done = 1'h0;
    @(posedge start);
    #37;
    repeat (128) begin
      link_clk = 1'h1;
      #200 link_clk = 1'h0;
      #190 rx = {rx[126:0], sdo};
      #10;
    end
    done = 1'h1;
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the identifier builder.
// Assumes udid_pkg, udid_builder and link_master_model are compiled first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic         core_clk, rstn, reg_wr, reg_rd, reset_device, rd_collision, link_clk;
  logic         udid_load, udid_sdo, udid_busy, notify_req, persist_ok, fixed_ok, lstart, ldone;
  logic [3:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, d, rnd;
  logic [15:0]  ssv, ssd, notify_status;
  logic [6:0]   own_addr, notify_host, notify_src;
  logic [127:0] udid, rx, e;
  int           num_errors, n_compared;

  udid_builder DUT (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nv_subsys_vendor(ssv), .nv_subsys_device(ssd), .reset_device(reset_device),
    .rd_collision(rd_collision), .own_addr(own_addr), .link_clk(link_clk),
    .udid_load(udid_load), .udid_sdo(udid_sdo), .udid_busy(udid_busy), .udid(udid),
    .notify_req(notify_req), .notify_host(notify_host), .notify_src(notify_src),
    .notify_status(notify_status), .persist_allowed(persist_ok), .fixed_allowed(fixed_ok));

  link_master_model partner (.start(lstart), .sdo(udid_sdo), .link_clk(link_clk),
    .rx(rx), .done(ldone));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Pulses an event input for exactly one sampling edge and stops just after that edge.
  task automatic pulse(input bit coll);
    @(posedge core_clk);
    if (coll) rd_collision <= 1'h1;
    else reset_device <= 1'h1;
    @(posedge core_clk);
    rd_collision <= 1'h0;
    reset_device <= 1'h0;
    #1;
  endtask
  function automatic logic [127:0] exp_id(input logic [31:0] c, input logic [31:0] ids,
                                          input logic [31:0] v);
    logic [15:0] sd;
    sd = (ssv == 16'h0000) ? 16'h0000 : ssd;
    return {c[1:0], 5'h00, c[2], 2'h0, udid_pkg::UDID_VERSION, c[10:8], ids[15:0], ids[31:16],
            9'h000, c[3], c[4], c[5], udid_pkg::BUS_VERSION, ssv, sd,
            (c[1:0] == udid_pkg::ATYPE_RANDOM) ? rnd : v};
  endfunction
  task automatic stop_test();
    $display("Compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Stimulus
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    int n;
    {rstn, reg_wr, reg_rd, reset_device, rd_collision, udid_load, lstart} = '0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    ssv = 16'h1234;
    ssd = 16'h5678;
    own_addr = 7'h2A;
    rnd = 32'h0000_0000;
    num_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'h1;
    tick(3);
    chk({udid_busy, udid_sdo, notify_req}, 128'h2);
    rd(udid_pkg::REG_CTRL);
    chk(d, 128'h0);
    rd(4'h9);
    chk(d, 128'h0);
    $display("Reset test done");
    // Every writable bit but the address type set, so reserved positions must be forced low by the builder.
    wr(udid_pkg::REG_CTRL, 32'hFFFF_FFFC);
    wr(udid_pkg::REG_IDS, 32'hBEEF_C0DE);
    wr(udid_pkg::REG_VSID_FIX, 32'h1357_9BDF);
    wr(udid_pkg::REG_UDID_W0, 32'hFFFF_FFFF);
    tick(6);
    e = exp_id(32'hFFFF_FFFC, 32'hBEEF_C0DE, 32'h1357_9BDF);
    chk(udid, e);
    for (int i = 0; i < 4; i++) begin
      rd(udid_pkg::REG_UDID_W3 + 4'(i));
      chk(d, e[127 - 32 * i -: 32]);
    end
    @(posedge core_clk);
    ssv <= 16'h0000;
    tick(6);
    chk(udid[47:32], 128'h0);
    @(posedge core_clk);
    ssv <= 16'h1234;
    $display("Layout test done");
    for (int t = 0; t < 4; t++) begin
      wr(udid_pkg::REG_CTRL, 32'h0000_0500 | t);
      rd(udid_pkg::REG_STATUS);
      rnd = d;
      tick(3);
      chk(udid, exp_id(32'h0000_0500 | t, 32'hBEEF_C0DE, 32'h1357_9BDF));
      chk({persist_ok, fixed_ok}, (t == 3) ? 2'h0 : 2'h3);
    end
    $display("Address type test done");
    wr(udid_pkg::REG_CTRL, 32'h0000_0543);
    tick(20);
    rd(udid_pkg::REG_STATUS);
    chk(d, rnd);
    pulse(1'h0);
    rd(udid_pkg::REG_STATUS);
    chk(d !== rnd, 1'h1);
    rnd = d;
    pulse(1'h1);
    chk({notify_req, notify_host, notify_src}, {1'h1, 7'h08, own_addr});
    tick(1);
    chk(notify_req, 1'h0);
    rd(udid_pkg::REG_STATUS);
    chk(d !== rnd, 1'h1);
    chk(notify_status, d[15:0]);
    rnd = d;
    tick(1);
    chk(udid[31:0], rnd);
    wr(udid_pkg::REG_CTRL, 32'h0000_0503);
    pulse(1'h1);
    chk(notify_req, 1'h0);
    rd(udid_pkg::REG_STATUS);
    rnd = d;
    $display("Random value test done");
    tick(3);
    @(posedge core_clk);
    udid_load <= 1'h1;
    @(posedge core_clk);
    udid_load <= 1'h0;
    tick(1);
    chk(udid_busy, 1'h1);
    lstart = 1'h1;
    for (n = 0; n < 4000 && ldone !== 1'h1; n++) @(posedge core_clk);
    if (ldone !== 1'h1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: link frame never finished", $time);
    end else begin
      tick(10);
      e = exp_id(32'h0000_0503, 32'hBEEF_C0DE, 32'h1357_9BDF);
      chk(rx, e);
      // The line keeps the last bit shifted; it idles high only before the first frame.
      chk({udid_busy, udid_sdo}, {1'h0, e[0]});
    end
    $display("Serial test done");
    stop_test();
  end
endmodule
`default_nettype wire
